// File: rtl/sbwdt_pkg.sv
// package of constants for the sign bit watchdog timer
package sbwdt_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SBWDT_COUNT_OFS = 8'h00;
    localparam logic [7:0] SBWDT_CTRL_OFS = 8'h04;
    localparam logic [7:0] SBWDT_FRZ_SET_OFS = 8'h08;
    localparam logic [7:0] SBWDT_FRZ_CLR_OFS = 8'h0C;
    localparam logic [7:0] SBWDT_STATUS_OFS = 8'h10;
    localparam logic [7:0] SBWDT_IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] SBWDT_IRQ_MASK_OFS = 8'h18;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int SBWDT_CNT_W = 9;
    localparam int SBWDT_SIGN_POS = 8;
    localparam int SBWDT_GUARD_LSB = 9;
    localparam int SBWDT_GUARD_W = 23;
    localparam int SBWDT_DIRECT_POS = 0;
    localparam int SBWDT_FREEZE_POS = 0;
    localparam int SBWDT_EV_W = 3;
    localparam int SBWDT_EV_NMI = 0;
    localparam int SBWDT_EV_RST = 1;
    localparam int SBWDT_EV_REJ = 2;

    // ------------------------------------------------------------
    // values after reset and thresholds
    // ------------------------------------------------------------
    localparam logic [8:0] SBWDT_CNT_RESET = 9'h0FF;
    localparam logic [8:0] SBWDT_CNT_LIMIT = 9'h1F0;
    localparam logic [8:0] SBWDT_CNT_ZERO = 9'h000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SBWDT_CLK_HZ = 100000000;
    localparam int SBWDT_TICK_US = 10240;
    localparam longint SBWDT_TICK_PROD = longint'(SBWDT_CLK_HZ) * longint'(SBWDT_TICK_US);
    localparam int SBWDT_TICK_CYCLES = int'(SBWDT_TICK_PROD / 64'd1000000);

endpackage : sbwdt_pkg

// File: rtl/sbwdt_tick.sv
// slow timebase divider producing one-cycle tick pulses
module sbwdt_tick #(
    parameter int TICK_CYCLES = 1024000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    output logic tick
);
    import sbwdt_pkg::*;

    localparam int CW = $clog2(TICK_CYCLES + 1);

    initial begin
        if (TICK_CYCLES < 2) begin
            $error("tick period must be at least two cycles");
        end
    end

    logic [CW-1:0] count;

    // divider keeps running while frozen so a tick is only suppressed, not delayed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick <= 1'b0;
        end else if (count == CW'(TICK_CYCLES - 1)) begin
            count <= '0;
            tick <= run;
        end else begin
            count <= count + CW'(1);
            tick <= 1'b0;
        end
    end

endmodule : sbwdt_tick

// File: rtl/sbwdt_top.sv
// sign bit watchdog timer with wishbone register access
//
// Function
// - The counter drops by exactly one on each tick of a 10.24 ms timebase.
// - Reset loads the counter with 255.
// - Past zero the count goes negative through sign bit 8, down to 1F0.
// - With direct reset clear, zero raises the NMI and -16 or below resets.
// - With direct reset set, a count at or below zero resets at once.
// - The timeout reset reinitialises counter, direct reset, freeze and NMI, counter back to 255.
// - The timeout reset leaves the boot remap selection untouched.
// - A debug halt stops counting and cannot be masked by software.
// - With direct reset clear, freeze set halts and freeze clear resumes.
// - Software can set direct reset but only a system reset clears it.
//
// Local design decisions: the placing of the registers and register access over Wishbone.
module sbwdt_top #(
    parameter int TICK_CYCLES = sbwdt_pkg::SBWDT_TICK_CYCLES,
    parameter int REMAP_W = 2
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // debug and boot
    input wire logic DEBUG_HALTED,
    input wire logic [REMAP_W-1:0] BOOT_REMAP_IN,
    output logic [REMAP_W-1:0] BOOT_REMAP_SELECT,
    // watchdog outputs
    output logic NMI,
    output logic SYS_RESET_REQ,
    output logic IRQ
);
    import sbwdt_pkg::*;

    initial begin
        if (REMAP_W < 1 || REMAP_W > 8) begin
            $error("REMAP_W must be 1 to 8");
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [SBWDT_CNT_W-1:0] count;
    logic direct_reset;
    logic timeout_freeze_bit;
    logic [SBWDT_EV_W-1:0] irq_status;
    logic [SBWDT_EV_W-1:0] irq_mask;
    logic sys_rst_pend;
    logic remap_caught;
    logic tick;
    logic run;
    logic soft_rst;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic bus_req;
    logic wr_cycle;
    logic wr_count;
    logic count_accept;
    logic wr_ctrl;
    logic wr_frz_set;
    logic wr_frz_clr;
    logic wr_irq_stat;
    logic wr_irq_mask;

    // byte lane 0 check, writes to control bits without lane 0 are ignored
    function automatic logic hit(input logic [7:0] ofs);
        return wr_cycle && WB_ADR_I == ofs && WB_SEL_I[0];
    endfunction : hit

    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_cycle = bus_req && WB_WE_I;
    assign wr_count = hit(SBWDT_COUNT_OFS) && (&WB_SEL_I);
    assign count_accept = wr_count && WB_DAT_I[31:SBWDT_GUARD_LSB] == '0;
    assign wr_ctrl = hit(SBWDT_CTRL_OFS);
    assign wr_frz_set = hit(SBWDT_FRZ_SET_OFS);
    assign wr_frz_clr = hit(SBWDT_FRZ_CLR_OFS);
    assign wr_irq_stat = hit(SBWDT_IRQ_STAT_OFS);
    assign wr_irq_mask = hit(SBWDT_IRQ_MASK_OFS);

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    // debug halt freezes regardless of software; software freeze only in nmi mode
    assign run = !DEBUG_HALTED && !(timeout_freeze_bit && !direct_reset);

    sbwdt_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .run(run),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // expiry detection
    // ------------------------------------------------------------
    logic [SBWDT_CNT_W-1:0] next_count;
    logic at_or_below_zero;
    logic at_or_below_limit;
    logic next_is_zero;

    always_comb begin
        next_count = count;
        if (count_accept) begin
            next_count = {1'b0, WB_DAT_I[SBWDT_CNT_W-2:0]};
        end else if (tick && count != SBWDT_CNT_LIMIT) begin
            next_count = count - 9'h001;
        end
    end

    // sign bit makes the count a 9-bit two's complement value
    assign at_or_below_zero = count[SBWDT_SIGN_POS] || count == SBWDT_CNT_ZERO;
    assign at_or_below_limit = count[SBWDT_SIGN_POS] && count <= SBWDT_CNT_LIMIT;
    assign next_is_zero = next_count == SBWDT_CNT_ZERO && count != SBWDT_CNT_ZERO;

    // ------------------------------------------------------------
    // system reset generation
    // ------------------------------------------------------------
    // a pending reset pulses the request and reinitialises counter, direct reset, freeze and nmi here
    assign soft_rst = sys_rst_pend;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sys_rst_pend <= 1'b0;
        end else if (sys_rst_pend) begin
            sys_rst_pend <= 1'b0;
        end else if (direct_reset && at_or_below_zero) begin
            sys_rst_pend <= 1'b1;
        end else if (!direct_reset && at_or_below_limit) begin
            sys_rst_pend <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SYS_RESET_REQ <= 1'b0;
        end else begin
            SYS_RESET_REQ <= sys_rst_pend;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            count <= SBWDT_CNT_RESET;
        end else if (soft_rst) begin
            count <= SBWDT_CNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // direct reset select, sticky until system reset
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            direct_reset <= 1'b0;
        end else if (soft_rst) begin
            direct_reset <= 1'b0;
        end else if (wr_ctrl && WB_DAT_I[SBWDT_DIRECT_POS]) begin
            direct_reset <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // software freeze
    // ------------------------------------------------------------
    // set wins when both strobes could coincide; they never do on one bus
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timeout_freeze_bit <= 1'b0;
        end else if (soft_rst) begin
            timeout_freeze_bit <= 1'b0;
        end else if (wr_frz_set && WB_DAT_I[SBWDT_FREEZE_POS]) begin
            timeout_freeze_bit <= 1'b1;
        end else if (wr_frz_clr && WB_DAT_I[SBWDT_FREEZE_POS]) begin
            timeout_freeze_bit <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // nmi, set on reaching zero in nmi mode, held below zero until reload or reset
    // ------------------------------------------------------------
    // nmi is latched at the zero crossing and dropped by a reload
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            NMI <= 1'b0;
        end else if (soft_rst || direct_reset) begin
            NMI <= 1'b0;
        end else if (next_is_zero) begin
            NMI <= 1'b1;
        end else if (count_accept) begin
            NMI <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // boot remap selection survives the timeout reset
    // ------------------------------------------------------------
    // caught once after power reset release; soft_rst deliberately not used
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            remap_caught <= 1'b0;
            BOOT_REMAP_SELECT <= '0;
        end else if (!remap_caught) begin
            remap_caught <= 1'b1;
            BOOT_REMAP_SELECT <= BOOT_REMAP_IN;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [SBWDT_EV_W-1:0] ev;

    assign ev[SBWDT_EV_NMI] = next_is_zero && !direct_reset && !soft_rst;
    assign ev[SBWDT_EV_RST] = sys_rst_pend;
    assign ev[SBWDT_EV_REJ] = wr_count && !count_accept;

    // events set over a same-cycle write-one-to-clear; status survives soft reset
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_status <= '0;
        end else begin
            irq_status <= ev | (irq_status & ~(wr_irq_stat ? WB_DAT_I[SBWDT_EV_W-1:0] : '0));
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_mask <= '0;
        end else if (wr_irq_mask) begin
            irq_mask <= WB_DAT_I[SBWDT_EV_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // wishbone answer, one wait-free cycle after the request
    // ------------------------------------------------------------
    logic [31:0] rd_data;

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (WB_ADR_I)
            SBWDT_COUNT_OFS: rd_data[SBWDT_CNT_W-1:0] = count;
            SBWDT_CTRL_OFS: rd_data[SBWDT_DIRECT_POS] = direct_reset;
            SBWDT_FRZ_SET_OFS: rd_data[SBWDT_FREEZE_POS] = timeout_freeze_bit;
            SBWDT_FRZ_CLR_OFS: rd_data[SBWDT_FREEZE_POS] = timeout_freeze_bit;
            SBWDT_STATUS_OFS: rd_data[3:0] = {DEBUG_HALTED, SYS_RESET_REQ, NMI, run};
            SBWDT_IRQ_STAT_OFS: rd_data[SBWDT_EV_W-1:0] = irq_status;
            SBWDT_IRQ_MASK_OFS: rd_data[SBWDT_EV_W-1:0] = irq_mask;
            default: rd_data = 32'h0000_0000; // unmapped reads zero, still acked
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

endmodule : sbwdt_top

// File: tb/sbwdt_props.sv
// checker of the watchdog port timing, bound to the top module
module sbwdt_props #(
    parameter int TICK_CYCLES = 8,
    parameter int REMAP_W = 2
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // debug, boot and watchdog outputs
    input wire logic DEBUG_HALTED,
    input wire logic [REMAP_W-1:0] BOOT_REMAP_SELECT,
    input wire logic NMI,
    input wire logic SYS_RESET_REQ
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    // bus answers exactly one cycle after a request is taken
    ack_next_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acknowledged next cycle");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("ack without request");
    data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    // timeout reset is a single pulse and clears the nmi
    req_pulse_a: assert property (SYS_RESET_REQ |=> !SYS_RESET_REQ)
        else $error("reset request longer than one cycle");
    req_nmi_a: assert property (SYS_RESET_REQ |-> !NMI)
        else $error("nmi survives timeout reset");
    // remap only moves at the first edge after a pin reset; two edges of history cover it
    remap_keep_a: assert property ($past(RESET_N, 2) |-> $stable(BOOT_REMAP_SELECT))
        else $error("remap selection changed");
    // a held debug halt leaves no tick to reach zero
    halt_freeze_a: assert property ((DEBUG_HALTED && !WB_CYC_I) [*4] |=> !$rose(NMI))
        else $error("nmi raised while halted");

    // main scenarios reached
    cover property ($rose(NMI));
    cover property (SYS_RESET_REQ);
    cover property (WB_ACK_O && WB_WE_I);
endmodule : sbwdt_props

bind sbwdt_top sbwdt_props #(.TICK_CYCLES(TICK_CYCLES), .REMAP_W(REMAP_W)) u_props (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .DEBUG_HALTED(DEBUG_HALTED), .BOOT_REMAP_SELECT(BOOT_REMAP_SELECT), .NMI(NMI),
    .SYS_RESET_REQ(SYS_RESET_REQ));

// File: tb/sbwdt_tb.sv
// self-checking bench of the sign bit watchdog timer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbwdt_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int TC = 8;
    logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, halt = 1'h1;
    logic nmi_seen = 1'h0, rst_seen = 1'h0, ack, nmi, rreq, irq;
    logic [7:0] adr = 8'h00;
    logic [7:0] v;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [1:0] bin = 2'h0, boot, remap;
    int fail_count = 0, checks = 0, seed = 31, n;

    // short tick so a full count fits the run
    sbwdt_top #(.TICK_CYCLES(TC)) uut (
        .SYS_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .DEBUG_HALTED(halt), .BOOT_REMAP_IN(bin), .BOOT_REMAP_SELECT(remap),
        .NMI(nmi), .SYS_RESET_REQ(rreq), .IRQ(irq));

    // 100 MHz clock
    always #5 clk = ~clk;

    // sticky flags of watchdog outputs
    always @(posedge clk) begin
        if (nmi === 1'h1) nmi_seen <= 1'h1;
        if (rreq === 1'h1) rst_seen <= 1'h1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'h1 && k < 40);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (k >= 40) chk(32'h0, 32'h1);
    endtask : wb

    // bounded wait for a level, n holds edges waited
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        while (s !== 1'h1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_hi

    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        bin = 2'($random(seed));
        boot = bin;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        wb(1'h0, SBWDT_COUNT_OFS, 32'h0);
        chk(q, 32'h0FF);
        wb(1'h0, 8'h1C, 32'h0);
        chk(q, 32'h0);
        bin <= ~boot;
        // halted: guarded writes kept, others dropped
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wb(1'h1, SBWDT_COUNT_OFS, {24'h0, v});
            wb(1'h1, SBWDT_COUNT_OFS, {23'($random(seed)) | 23'h1, 9'h0AA});
            wb(1'h0, SBWDT_COUNT_OFS, 32'h0);
            chk(q, {24'h0, v});
        end
        wb(1'h1, SBWDT_COUNT_OFS, 32'hFFFFFFFF);
        repeat (10 * TC) @(posedge clk);
        wb(1'h0, SBWDT_COUNT_OFS, 32'h0);
        chk(q, {24'h0, v});
        // rejected write event: masked, unmasked, cleared
        chk(32'(irq), 32'h0);
        wb(1'h0, SBWDT_IRQ_STAT_OFS, 32'h0);
        chk(32'(q[SBWDT_EV_REJ]), 32'h1);
        wb(1'h1, SBWDT_IRQ_MASK_OFS, 32'h4);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h1);
        wb(1'h1, SBWDT_IRQ_STAT_OFS, 32'h4);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        // software freeze, then nmi to timeout distance
        wb(1'h1, SBWDT_FRZ_SET_OFS, 32'h1);
        wb(1'h1, SBWDT_COUNT_OFS, 32'h3);
        halt <= 1'h0;
        repeat (10 * TC) @(posedge clk);
        wb(1'h0, SBWDT_COUNT_OFS, 32'h0);
        chk(q, 32'h3);
        wb(1'h1, SBWDT_FRZ_CLR_OFS, 32'h1);
        wait_hi(nmi, 20 * TC);
        chk(32'(nmi), 32'h1);
        wait_hi(rreq, 20 * TC);
        // sixteen ticks to the limit, one edge to pend, one to the request
        chk(n, 16 * TC + 2);
        repeat (2) @(posedge clk);
        wb(1'h0, SBWDT_COUNT_OFS, 32'h0);
        chk(q, 32'h0FF);
        chk(32'(remap), 32'(boot));
        // nmi handler reload keeps the reset away
        wb(1'h1, SBWDT_COUNT_OFS, 32'h1);
        wait_hi(nmi, 4 * TC);
        repeat (TC) @(posedge clk);
        wb(1'h0, SBWDT_COUNT_OFS, 32'h0);
        chk(q, 32'h1FF);
        wb(1'h1, SBWDT_COUNT_OFS, 32'h14);
        chk(32'(nmi), 32'h0);
        rst_seen = 1'h0;
        repeat (17 * TC) @(posedge clk);
        chk(32'(rst_seen), 32'h0);
        // direct mode: sticky select, no freeze, no nmi
        halt <= 1'h1;
        wb(1'h1, SBWDT_CTRL_OFS, 32'h1);
        wb(1'h1, SBWDT_CTRL_OFS, 32'h0);
        wb(1'h0, SBWDT_CTRL_OFS, 32'h0);
        chk(q, 32'h1);
        wb(1'h1, SBWDT_FRZ_SET_OFS, 32'h1);
        wb(1'h1, SBWDT_COUNT_OFS, 32'h2);
        nmi_seen = 1'h0;
        halt <= 1'h0;
        wait_hi(rreq, 4 * TC);
        chk(32'(rreq), 32'h1);
        chk(32'(nmi_seen), 32'h0);
        repeat (2) @(posedge clk);
        wb(1'h0, SBWDT_CTRL_OFS, 32'h0);
        chk(q, 32'h0);
        results();
    end

    // hang guard well beyond the expected run
    initial begin
        #200us;
        fail_count++;
        results();
    end
endmodule : testbench
